/* hw/gtd_consts.vh */
// Constants for the gated totalize and interval delay control block.
// Assumes a 40 MHz clock and a plain strobe-based register port.
`ifndef GTD_CONSTS_VH
`define GTD_CONSTS_VH
// Register offsets
`define OFS_CTRL        4'h0
`define OFS_DELAY_TIME  4'h1
`define OFS_APERTURE    4'h2
`define OFS_STATUS      4'h3
`define OFS_OPER_ENA    4'h4
`define OFS_QUES_ENA    4'h5
`define OFS_GATE_SRC    4'h6
// Control fields
`define CTRL_SRC_LSB    0
`define CTRL_SRC_MSB    1
`define CTRL_DLY_EN     2
`define CTRL_GATE_EN    3
`define CTRL_GATE_INV   4
`define CTRL_TI_MODE    5
`define CTRL_ABORT      6
`define CTRL_GATE_CH    7
// Timebase source codes
`define SRC_BACKPLANE   2'h0
`define SRC_INTERNAL    2'h1
`define SRC_EXTERNAL    2'h2
// Gate source codes
`define GATE_SRC_CH1    2'h1
`define GATE_SRC_CH2    2'h2
// Reset values, delay limits and error code
`define RST_DELAY_MS    17'h00064
`define RST_APERTURE    32'h00000000
`define MAX_DELAY_MS    17'h1869F
`define MIN_DELAY_MS    17'h00001
`define ERR_HW_MISSING  16'hFF0F
// Timing
`define CLK_HZ          40000000
`define TICK_MS_NS      1000000
`define CLK_NS          25
`define TICK_CYCLES     (`TICK_MS_NS / `CLK_NS)
`endif

/* hw/gated_totalize_delay_control.v */
// Measurement control: timebase select, shared aperture, interval delay, gated totalize.
// Assumes register master on i_clk; channel and arm inputs are asynchronous.
//
// What this block does
// - One shared aperture setting; latest write is used by every measurement.
// - Timebase chosen from backplane, internal oscillator or external reference.
// - Reset selects the backplane timebase.
// - Absent source is refused and reports the hardware-missing error code.
// - With delay enabled, stop-arm events are ignored until delay elapses.
// - With delay disabled, stop-arm passes straight through, no inhibit.
// - Delay range 1 ms to 99.999 s, default 100 ms.
// - Delay held in whole milliseconds; fractions truncated.
// - Delay written while disabled is stored but changes nothing.
// - Delay time reads back regardless of enable.
// - Delay enable reads back as 1 or 0.
// - Delay acts only on time-interval measurements.
// - Gated totalize counts selected channel only while other channel gates.
// - Exactly one gate pulse is accumulated, then counting stops.
// - Gate active high under normal polarity, low under inverted.
// - Reset disables gated totalize and sets normal polarity.
// - Gate source reads channel one or channel two code.
// - Operation and questionable enables accept 0..32767 and reset to 0.
//
// Chosen here: strobed register access and the address map.
`default_nettype none
`include "gtd_consts.vh"
module gated_totalize_delay_control (
  input  wire        i_clk,
  input  wire        i_rst_b,
  input  wire [3:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rdata,
  input  wire        i_int_osc_present,
  input  wire        i_ext_ref_present,
  input  wire        i_ch1,
  input  wire        i_ch2,
  input  wire        i_start_arm,
  input  wire        i_stop_arm,
  output reg  [1:0]  o_timebase_sel,
  output reg  [31:0] o_aperture,
  output reg         o_stop_arm,
  output reg  [31:0] o_total,
  output reg         o_gate_done,
  output reg         o_err_valid,
  output reg  [15:0] o_err_code
);
  // ********************************************************
  // Input synchronisers
  // ********************************************************
  // Presence, channel and arm pins are asynchronous to i_clk
  wire [5:0] pin_in = {i_int_osc_present, i_ext_ref_present, i_ch1, i_ch2, i_start_arm, i_stop_arm};
  wire [5:0] sync_r;
  genvar     gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
      reg meta_r;
      reg sync_bit_r;
      // Only the second stage is read; the first may still be settling
      always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          meta_r     <= 1'b0;
          sync_bit_r <= 1'b0;
        end else begin
          meta_r     <= pin_in[gi];
          sync_bit_r <= meta_r;
        end
      end
      assign sync_r[gi] = sync_bit_r;
    end
  endgenerate
  wire int_ok   = sync_r[5];
  wire ext_ok   = sync_r[4];
  wire ch1_s    = sync_r[3];
  wire ch2_s    = sync_r[2];
  wire start_s  = sync_r[1];
  wire stop_s   = sync_r[0];
  reg  [3:0] prev_r;
  wire start_rise = start_s & ~prev_r[0];
  wire stop_rise  = stop_s & ~prev_r[1];

  // ********************************************************
  // Registers
  // ********************************************************
  reg [1:0]  src_r;
  reg        dly_en_r;
  reg        gate_en_r;
  reg        gate_inv_r;
  reg        ti_mode_r;
  reg        gate_ch_r;
  reg [16:0] dly_ms_r;
  reg [31:0] aper_r;
  reg [14:0] oper_ena_r;
  reg [14:0] ques_ena_r;
  reg        abort_r;
  wire wr_ctrl = i_wr && (i_addr == `OFS_CTRL);
  wire [1:0] new_src = i_wdata[`CTRL_SRC_MSB:`CTRL_SRC_LSB];
  wire src_ok = (new_src == `SRC_BACKPLANE) ||
                (new_src == `SRC_INTERNAL && int_ok) ||
                (new_src == `SRC_EXTERNAL && ext_ok);
  // Millisecond count already integral; clamp keeps the range
  reg [16:0] wr_ms;
  always @* begin
    if (i_wdata[31:17] != 15'h0000 || i_wdata[16:0] > `MAX_DELAY_MS) begin
      wr_ms = `MAX_DELAY_MS;
    end else if (i_wdata[16:0] < `MIN_DELAY_MS) begin
      wr_ms = `MIN_DELAY_MS;
    end else begin
      wr_ms = i_wdata[16:0];
    end
  end

  wire wr_dly  = i_wr && (i_addr == `OFS_DELAY_TIME);
  wire wr_aper = i_wr && (i_addr == `OFS_APERTURE);
  wire wr_oper = i_wr && (i_addr == `OFS_OPER_ENA);
  wire wr_ques = i_wr && (i_addr == `OFS_QUES_ENA);

  // ********************************************************
  // Timebase source and error report
  // ********************************************************
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      src_r       <= `SRC_BACKPLANE;
      o_err_valid <= 1'b0;
      o_err_code  <= 16'h0000;
    end else begin
      o_err_valid <= 1'b0;
      // A missing source is refused; previous timebase stays
      if (wr_ctrl && src_ok) begin
        src_r <= new_src;
      end
      if (wr_ctrl && !src_ok) begin
        o_err_valid <= 1'b1;
        o_err_code  <= `ERR_HW_MISSING;
      end
    end
  end

  // ********************************************************
  // Control bits
  // ********************************************************
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dly_en_r   <= 1'b0;
      gate_en_r  <= 1'b0;
      gate_inv_r <= 1'b0;
      ti_mode_r  <= 1'b0;
      gate_ch_r  <= 1'b0;
      abort_r    <= 1'b0;
    end else begin
      // Abort is a one-cycle pulse and never reads back
      abort_r <= wr_ctrl & i_wdata[`CTRL_ABORT];
      if (wr_ctrl) begin
        dly_en_r   <= i_wdata[`CTRL_DLY_EN];
        gate_en_r  <= i_wdata[`CTRL_GATE_EN];
        gate_inv_r <= i_wdata[`CTRL_GATE_INV];
        ti_mode_r  <= i_wdata[`CTRL_TI_MODE];
        gate_ch_r  <= i_wdata[`CTRL_GATE_CH];
      end
    end
  end

  // ********************************************************
  // Delay time and aperture
  // ********************************************************
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dly_ms_r <= `RST_DELAY_MS;
      aper_r   <= `RST_APERTURE;
    end else begin
      // Kept even while the delay is off; only the inhibit load and the readback read it
      if (wr_dly) begin
        dly_ms_r <= wr_ms;
      end
      if (wr_aper) begin
        aper_r <= i_wdata;
      end
    end
  end

  // ********************************************************
  // Status enable masks
  // ********************************************************
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      oper_ena_r <= 15'h0000;
      ques_ena_r <= 15'h0000;
    end else begin
      // Bit 15 does not exist, so 32767 is the largest mask
      if (wr_oper) begin
        oper_ena_r <= i_wdata[14:0];
      end
      if (wr_ques) begin
        ques_ena_r <= i_wdata[14:0];
      end
    end
  end

  // ********************************************************
  // Interval delay inhibit
  // ********************************************************
  reg [15:0] tick_r;
  reg [16:0] ms_left_r;
  reg        inhibit_r;
  wire tick = (tick_r == (`TICK_CYCLES - 1));
  // Inhibit only in interval mode with delay enabled
  wire start_load = start_rise && ti_mode_r && dly_en_r;

  // ********************************************************
  // Edge history
  // ********************************************************
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev_r <= 4'h0;
    end else begin
      prev_r <= {ch2_s, ch1_s, stop_s, start_s};
    end
  end

  // ********************************************************
  // Millisecond prescaler
  // ********************************************************
  // Restarting on a start arm makes the first millisecond a whole one
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_r <= 16'h0000;
    end else if (start_load) begin
      tick_r <= 16'h0000;
    end else begin
      tick_r <= tick ? 16'h0000 : tick_r + 16'h0001;
    end
  end

  // ********************************************************
  // Delay countdown
  // ********************************************************
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ms_left_r <= 17'h00000;
      inhibit_r <= 1'b0;
    end else begin
      if (start_load) begin
        ms_left_r <= dly_ms_r;
        inhibit_r <= 1'b1;
      end else if (inhibit_r && tick) begin
        if (ms_left_r == 17'h00001) begin
          inhibit_r <= 1'b0;
        end
        ms_left_r <= ms_left_r - 17'h00001;
      end
      // Abort ends the inhibit too, so a stale delay never blocks a new run
      if (abort_r || !dly_en_r) begin
        inhibit_r <= 1'b0;
      end
    end
  end

  // ********************************************************
  // Stop arm output
  // ********************************************************
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_stop_arm <= 1'b0;
    end else begin
      o_stop_arm <= stop_rise & ~(inhibit_r & dly_en_r & ti_mode_r);
    end
  end

  // ********************************************************
  // Gated totalize
  // ********************************************************
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_DONE = 3'b100;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  // Gate from the opposite channel; edge seen on the other one
  wire gate_raw   = gate_ch_r ? ch2_s : ch1_s;
  wire gate_act   = gate_raw ^ gate_inv_r;
  wire cnt_raw    = gate_ch_r ? ch1_s : ch2_s;
  wire cnt_prev   = gate_ch_r ? prev_r[2] : prev_r[3];
  wire gate_prev  = (gate_ch_r ? prev_r[3] : prev_r[2]) ^ gate_inv_r;
  wire cnt_rise   = cnt_raw & ~cnt_prev;
  // ********************************************************
  // Gate state machine
  // ********************************************************
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        // Opens only on an inactive-to-active gate edge
        if (gate_en_r && gate_act && !gate_prev) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!gate_act) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        // Later gate pulses are ignored until the host aborts or clears gate enable
        state_nxt = ST_DONE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (abort_r || !gate_en_r) begin
      state_nxt = ST_IDLE;
    end
  end

  // ********************************************************
  // Event count
  // ********************************************************
  reg [31:0] total_nxt;
  always @* begin
    total_nxt = o_total;
    if (abort_r) begin
      total_nxt = 32'h00000000;
    end else if (state_r == ST_WAIT && gate_act && cnt_rise) begin
      total_nxt = o_total + 32'h00000001;
    end
  end

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r     <= ST_IDLE;
      o_total     <= 32'h00000000;
      o_gate_done <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      o_gate_done <= (state_nxt == ST_DONE);
      o_total     <= total_nxt;
    end
  end

  // ********************************************************
  // Outputs and readback
  // ********************************************************
  reg [31:0] rdata_nxt;
  always @* begin
    rdata_nxt = 32'h00000000;
    if (i_rd) begin
      case (i_addr)
        `OFS_CTRL:       rdata_nxt = {24'h000000, gate_ch_r, 1'b0, ti_mode_r, gate_inv_r,
                                      gate_en_r, dly_en_r, src_r};
        `OFS_DELAY_TIME: rdata_nxt = {15'h0000, dly_ms_r};
        `OFS_APERTURE:   rdata_nxt = aper_r;
        `OFS_STATUS:     rdata_nxt = {27'h0000000, inhibit_r, state_r == ST_DONE,
                                      state_r == ST_WAIT, ext_ok, int_ok};
        `OFS_OPER_ENA:   rdata_nxt = {17'h00000, oper_ena_r};
        `OFS_QUES_ENA:   rdata_nxt = {17'h00000, ques_ena_r};
        `OFS_GATE_SRC:   rdata_nxt = {30'h00000000, gate_ch_r ? `GATE_SRC_CH2 : `GATE_SRC_CH1};
        // Unmapped indices read as zero
        default:         rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_timebase_sel <= `SRC_BACKPLANE;
      o_aperture     <= `RST_APERTURE;
      o_rdata        <= 32'h00000000;
    end else begin
      o_timebase_sel <= src_r;
      o_aperture     <= aper_r;
      // Read data stand for one cycle, then fall back to zero
      o_rdata        <= rdata_nxt;
    end
  end
endmodule
`default_nettype wire

/* sim/gtd_checker_assertions.sv */
// Port checker for the measurement control block.
// Assumes presence inputs stay steady around source writes.
`default_nettype none
module gtd_checker (
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic [3:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic        i_int_osc_present,
  input wire logic        i_ext_ref_present,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0]  o_timebase_sel,
  input wire logic [31:0] o_aperture,
  input wire logic        o_stop_arm,
  input wire logic [31:0] o_total,
  input wire logic        o_gate_done,
  input wire logic        o_err_valid,
  input wire logic [15:0] o_err_code
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Properties
  // ****
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  property p_rd_idle; !$past(i_rd) |-> o_rdata == 32'h0; endproperty
  property p_ap; i_wr && i_addr == 4'h2 |-> ##2 o_aperture == $past(i_wdata, 2); endproperty
  property p_dly; i_rd && i_addr == 4'h1 |=> o_rdata >= 32'h1 && o_rdata <= 32'h1869F; endproperty
  property p_src; i_rd && i_addr == 4'h6 |=> o_rdata == 32'h1 || o_rdata == 32'h2; endproperty
  property p_oper; i_rd && (i_addr == 4'h4 || i_addr == 4'h5) |=> o_rdata[31:15] == 17'h0; endproperty
  property p_tb; i_wr && i_addr == 4'h0 && i_wdata[1:0] == 2'h2 && i_ext_ref_present |=> ##1 o_timebase_sel == 2'h2;
  endproperty
  property p_refuse; i_wr && i_addr == 4'h0 && i_wdata[1:0] == 2'h1 && !i_int_osc_present
    |=> o_err_valid ##1 $stable(o_timebase_sel); endproperty
  property p_code; o_err_valid |=> o_err_code == 16'hFF0F; endproperty
  property p_rst; $rose(i_rst_b) |-> o_timebase_sel == 2'h0; endproperty
  property p_frozen; o_gate_done && !i_wr && !$past(i_wr) |=> $stable(o_total); endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_ap: assert property (p_ap) else $error("aperture not latest write");
  a_dly: assert property (p_dly) else $error("delay out of range");
  a_src: assert property (p_src) else $error("gate source code bad");
  a_oper: assert property (p_oper) else $error("enable mask too wide");
  a_tb: assert property (p_tb) else $error("timebase not switched");
  a_refuse: assert property (p_refuse) else $error("absent source not refused");
  a_code: assert property (p_code) else $error("wrong error code");
  a_rst: assert property (p_rst) else $error("timebase not backplane at reset");
  a_frozen: assert property (p_frozen) else $error("count moved after gate");
  c_err: cover property (o_err_valid);
  c_done: cover property ($rose(o_gate_done));
  c_stop: cover property (o_stop_arm);
endmodule
bind gated_totalize_delay_control gtd_checker i_chk (.i_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd,
  .i_int_osc_present, .i_ext_ref_present, .o_rdata, .o_timebase_sel, .o_aperture, .o_stop_arm, .o_total,
  .o_gate_done, .o_err_valid, .o_err_code);
`default_nettype wire

/* sim/host_model.sv */
// Host register master for the measurement control block.
// Assumes one clock; strobes one cycle, read data the cycle after.
`default_nettype none
module host_model (
  input  wire logic        i_clk,
  input  wire logic [31:0] i_rdata,
  output var  logic [3:0]  o_addr,
  output var  logic [31:0] o_wdata,
  output var  logic        o_wr,
  output var  logic        o_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_addr = 4'h0;
    o_wdata = 32'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

/* sim/test_gated_totalize_delay_control.sv */
// Self-checking bench for the measurement control block.
// Assumes internal oscillator absent, external reference present.
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin mismatches++; $display("ERROR %s exp %0h seen %0h", n, e, s); end end
module test_gated_totalize_delay_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_ch1 = 1'b0, i_ch2 = 1'b0, i_start_arm = 1'b0, i_stop_arm = 1'b0;
  logic i_wr, i_rd, o_stop_arm, o_gate_done, o_err_valid;
  logic [3:0] i_addr;
  logic [1:0] o_timebase_sel;
  logic [15:0] o_err_code;
  logic [31:0] i_wdata, o_rdata, o_aperture, o_total, rv;
  int mismatches, comparisons, stops, cycles;
  gated_totalize_delay_control i_gated_totalize_delay_control (.i_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_int_osc_present(1'b0), .i_ext_ref_present(1'b1), .i_ch1, .i_ch2, .i_start_arm, .i_stop_arm,
    .o_timebase_sel, .o_aperture, .o_stop_arm, .o_total, .o_gate_done, .o_err_valid, .o_err_code);
  host_model p_host (.i_clk, .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
  // ****
  // Clock, watchdog, helpers
  // ****
  initial forever #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    stops += (o_stop_arm === 1'b1);
    cycles++;
    if (cycles == 95000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic rchk(input string n, input logic [3:0] a, input logic [31:0] e);
    p_host.rd(a, rv);
    `CHK(n, e, rv)
  endtask
  task automatic arm(input bit stp);
    if (stp) i_stop_arm <= 1'b1; else i_start_arm <= 1'b1;
    cyc(3);
    i_stop_arm <= 1'b0;
    i_start_arm <= 1'b0;
    cyc(8);
  endtask
  task automatic ch2_pulses(input int n);
    repeat (n) begin
      i_ch2 <= 1'b1;
      cyc(4);
      i_ch2 <= 1'b0;
      cyc(4);
    end
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    rchk("delay", 4'h1, 32'h64);
    rchk("gsrc", 4'h6, 32'h1);
    rchk("oper", 4'h4, 32'h0);
    rchk("ctrl", 4'h0, 32'h0);
    `CHK("tb", 2'h0, o_timebase_sel)
    p_host.wr(4'h0, 32'h1);
    cyc(2);
    `CHK("err", 16'hFF0F, o_err_code)
    `CHK("tb", 2'h0, o_timebase_sel)
    p_host.wr(4'h0, 32'h2);
    cyc(2);
    `CHK("tb", 2'h2, o_timebase_sel)
    p_host.wr(4'h0, 32'h80);
    rchk("gsrc", 4'h6, 32'h2);
    p_host.wr(4'h1, 32'h0);
    rchk("dmin", 4'h1, 32'h1);
    p_host.wr(4'h1, 32'd100000);
    rchk("dmax", 4'h1, 32'd99999);
    p_host.wr(4'h0, 32'h4);
    rchk("den", 4'h0, 32'h4);
    rchk("dtime", 4'h1, 32'd99999);
    p_host.wr(4'h2, 32'h12345678);
    rchk("ap", 4'h2, 32'h12345678);
    `CHK("apout", 32'h12345678, o_aperture)
    p_host.wr(4'h5, 32'hFFFF);
    rchk("ques", 4'h5, 32'h7FFF);
    p_host.wr(4'hF, 32'h5);
    rchk("unmapped", 4'hF, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_stop();
    int s0;
    p_host.wr(4'h1, 32'h2);
    p_host.wr(4'h0, 32'h20);
    arm(0);
    s0 = stops;
    arm(1);
    `CHK("no delay", s0 + 1, stops)
    p_host.wr(4'h0, 32'h4);
    arm(0);
    arm(1);
    `CHK("not TI", s0 + 2, stops)
    p_host.wr(4'h0, 32'h24);
    arm(0);
    arm(1);
    `CHK("inhibit", s0 + 2, stops)
    cyc(80100);
    arm(1);
    `CHK("expired", s0 + 3, stops)
    $display("t_stop done");
  endtask
  task automatic t_gate(input bit inv);
    i_ch1 <= inv;
    p_host.wr(4'h0, {27'h0, inv, 4'h8});
    ch2_pulses(1);
    i_ch1 <= !inv;
    cyc(8);
    ch2_pulses(3);
    i_ch1 <= inv;
    cyc(8);
    `CHK("done", 1'b1, o_gate_done)
    `CHK("total", 32'h3, o_total)
    i_ch1 <= !inv;
    cyc(8);
    ch2_pulses(2);
    i_ch1 <= inv;
    cyc(8);
    `CHK("one pulse", 32'h3, o_total)
    p_host.wr(4'h0, 32'h40);
    cyc(4);
    `CHK("abort", 32'h0, o_total)
    $display("t_gate done");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(12);
    i_rst_b <= 1'b1;
    t_regs();
    t_stop();
    t_gate(1'b0);
    t_gate(1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
